//--- include/fbs_map.svh
`ifndef FBS_MAP_SVH
`define FBS_MAP_SVH
// ************
// register offsets
// ************
`define FBS_OFF_CTRL 8'h00
`define FBS_OFF_STATION 8'h04
`define FBS_OFF_STATUS 8'h08
`define FBS_OFF_TXDATA 8'h0c
`define FBS_OFF_RXDATA 8'h10
`define FBS_OFF_COUNTS 8'h14
// ************
// ctrl fields
// ************
`define FBS_CTRL_ROLE_LSB 0
`define FBS_CTRL_RATE_LSB 2
`define FBS_CTRL_PAR_LSB 5
`define FBS_CTRL_STOP2_BIT 7
`define FBS_CTRL_K1_BIT 8
`define FBS_CTRL_REMOTE_BIT 9
`define FBS_CTRL_CRC_BIT 10
`define FBS_CTRL_RESET 32'h0000_0000
// ************
// timing
// ************
`define FBS_CLK_HZ 50000000
`define FBS_FAST_BAUD 375000
`define FBS_SLOW_BAUD_X10 1875000
`define FBS_DIV_FAST (`FBS_CLK_HZ / `FBS_FAST_BAUD)
`define FBS_DIV_SLOW ((`FBS_CLK_HZ * 10) / `FBS_SLOW_BAUD_X10)
`define FBS_DIV_SER(r) (`FBS_CLK_HZ / (r))
`define FBS_FIFO_DEPTH 16
`define FBS_MASTER_LINE 1'b0
`define FBS_SLAVE_LINE 1'b1
`endif

//--- include/fbs_pkg.sv
package fbs_pkg;
  typedef enum logic [1:0] {
    FBS_ROLE_MASTER = 2'b00,
    FBS_ROLE_ISLAVE = 2'b01,
    FBS_ROLE_SERIAL = 2'b10
  } fbs_role_e;
  typedef enum logic [1:0] {
    FBS_PAR_NONE = 2'b00,
    FBS_PAR_EVEN = 2'b01,
    FBS_PAR_ODD = 2'b10
  } fbs_par_e;
  typedef enum logic [1:0] {
    FBS_ST_IDLE = 2'b00,
    FBS_ST_START = 2'b01,
    FBS_ST_BITS = 2'b10,
    FBS_ST_STOP = 2'b11
  } fbs_st_e;
endpackage

//--- rtl/fbs_fifo.sv
module fbs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wp_ff;
  logic [AW-1:0] rp_ff;
  logic [AW:0] cnt_ff;
  logic push;
  logic pop;
  assign in_ready = (cnt_ff != DEPTH[AW:0]);
  assign out_valid = (cnt_ff != '0);
  assign out_data = mem_ff[rp_ff];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wp_ff] <= in_data;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) begin
        wp_ff <= wp_ff + 1'b1;
      end
      if (pop) begin
        rp_ff <= rp_ff + 1'b1;
      end
      cnt_ff <= cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule

//--- rtl/fbs_station.sv
`include "fbs_map.svh"
module fbs_station (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic HSEL,
  input wire logic [7:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic RXD,
  output logic TXD,
  output logic TX_OE_N,
  input wire logic MASTER_RUN,
  input wire logic SELECTOR_HALT,
  output logic RUN_STATE,
  output logic [3:0] BUS_ADDR,
  output logic LINE_NUM
);
  // ************
  // bus slave
  // ************
  logic [31:0] ctrl_ff;
  logic [3:0] station_ff;
  logic [15:0] counts_ff;
  logic [7:0] addr_ff;
  logic wr_ff;
  logic rd_ff;
  logic pe_ff;
  logic fe_ff;
  logic ovr_ff;
  logic [31:0] nxt_rdata;
  logic tx_in_valid;
  logic tx_in_ready;
  logic rx_out_valid;
  logic rx_out_ready;
  logic [7:0] rx_out_data;
  logic rx_push;
  logic rx_in_ready;
  logic [7:0] rx_byte_ff;
  logic rx_done;
  logic rx_pe;
  logic rx_fe;
  wire logic take = HSEL && HREADY && HTRANS[1];
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      addr_ff <= 8'h00;
      wr_ff <= 1'b0;
      rd_ff <= 1'b0;
    end else begin
      addr_ff <= HADDR;
      wr_ff <= take && HWRITE;
      rd_ff <= take && !HWRITE;
    end
  end
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      ctrl_ff <= `FBS_CTRL_RESET;
      station_ff <= 4'h1;
      counts_ff <= 16'h0000;
    end else if (wr_ff) begin
      case (addr_ff)
        `FBS_OFF_CTRL: ctrl_ff <= {21'h000000, HWDATA[10:0]};
        `FBS_OFF_STATION: station_ff <= HWDATA[3:0];
        // byte counts are software's duty to match on both ends
        `FBS_OFF_COUNTS: counts_ff <= HWDATA[15:0];
        default: ;
      endcase
    end
  end
  assign tx_in_valid = wr_ff && (addr_ff == `FBS_OFF_TXDATA);
  assign rx_out_ready = rd_ff && (addr_ff == `FBS_OFF_RXDATA);
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    case (addr_ff)
      `FBS_OFF_CTRL: nxt_rdata = ctrl_ff;
      `FBS_OFF_STATION: nxt_rdata = {28'h0000000, station_ff};
      `FBS_OFF_STATUS: nxt_rdata = {26'h0000000, RUN_STATE, ovr_ff, fe_ff, pe_ff, rx_out_valid, tx_in_ready};
      `FBS_OFF_RXDATA: nxt_rdata = {23'h000000, rx_out_valid, rx_out_data};
      `FBS_OFF_COUNTS: nxt_rdata = {16'h0000, counts_ff};
      default: nxt_rdata = 32'h0000_0000;
    endcase
  end
  // combinational read path would break the flop-output style, so data arrives one cycle late
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      HRDATA <= 32'h0000_0000;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end else begin
      HREADYOUT <= !(take && !HWRITE);
      if (rd_ff) begin
        HRDATA <= nxt_rdata;
      end
    end
  end
  // ************
  // config decode
  // ************
  wire fbs_pkg::fbs_role_e role = fbs_pkg::fbs_role_e'(ctrl_ff[`FBS_CTRL_ROLE_LSB +: 2]);
  wire fbs_pkg::fbs_par_e par = fbs_pkg::fbs_par_e'(ctrl_ff[`FBS_CTRL_PAR_LSB +: 2]);
  wire logic [2:0] rate_sel = ctrl_ff[`FBS_CTRL_RATE_LSB +: 3];
  // two stop bits only without parity
  wire logic stop2 = ctrl_ff[`FBS_CTRL_STOP2_BIT] && (par == fbs_pkg::FBS_PAR_NONE);
  wire logic serial_comm_mode = (role == fbs_pkg::FBS_ROLE_SERIAL);
  // 18 bits: the 300 baud bit time does not fit in 16
  logic [17:0] div;
  always_comb begin
    div = 18'(`FBS_DIV_FAST);
    if (serial_comm_mode) begin
      case (rate_sel)
        3'h0: div = 18'(`FBS_DIV_SER(300));
        3'h1: div = 18'(`FBS_DIV_SER(600));
        3'h2: div = 18'(`FBS_DIV_SER(1200));
        3'h3: div = 18'(`FBS_DIV_SER(2400));
        3'h4: div = 18'(`FBS_DIV_SER(4800));
        3'h5: div = 18'(`FBS_DIV_SER(9600));
        default: div = 18'(`FBS_DIV_SER(19200));
      endcase
    end else if (ctrl_ff[`FBS_CTRL_K1_BIT]) begin
      div = 18'(`FBS_DIV_SLOW);
    end
  end
  // ************
  // station identity and run mirror
  // ************
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      BUS_ADDR <= 4'h0;
      LINE_NUM <= `FBS_MASTER_LINE;
    end else if (role == fbs_pkg::FBS_ROLE_MASTER) begin
      BUS_ADDR <= 4'h0;
      LINE_NUM <= `FBS_MASTER_LINE;
    end else begin
      BUS_ADDR <= station_ff + 4'h1;
      LINE_NUM <= `FBS_SLAVE_LINE;
    end
  end
  logic [2:0] run_sync_ff;
  logic [2:0] halt_sync_ff;
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      run_sync_ff <= 3'h0;
      halt_sync_ff <= 3'h7;
      RUN_STATE <= 1'b0;
    end else begin
      run_sync_ff <= {run_sync_ff[1:0], MASTER_RUN};
      halt_sync_ff <= {halt_sync_ff[1:0], SELECTOR_HALT};
      if (halt_sync_ff[2] && halt_sync_ff[1]) begin
        RUN_STATE <= 1'b0;
      end else if (ctrl_ff[`FBS_CTRL_REMOTE_BIT] && role == fbs_pkg::FBS_ROLE_ISLAVE &&
                   run_sync_ff[2] == run_sync_ff[1]) begin
        RUN_STATE <= run_sync_ff[2];
      end
    end
  end
  // crc on/off is carried in ctrl for the framing layer outside this block
  // ************
  // tx path
  // ************
  logic tx_out_valid;
  logic tx_out_ready;
  logic [7:0] tx_out_data;
  fbs_fifo #(.WIDTH(8), .DEPTH(`FBS_FIFO_DEPTH)) u_txq (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .in_valid(tx_in_valid),
    .in_ready(tx_in_ready),
    .in_data(HWDATA[7:0]),
    .out_valid(tx_out_valid),
    .out_ready(tx_out_ready),
    .out_data(tx_out_data)
  );
  fbs_pkg::fbs_st_e tx_st_ff;
  logic [17:0] tx_cnt_ff;
  logic [3:0] tx_bit_ff;
  logic [9:0] tx_sh_ff;
  wire logic par_bit = ^tx_out_data ^ (par == fbs_pkg::FBS_PAR_ODD);
  assign tx_out_ready = (tx_st_ff == fbs_pkg::FBS_ST_IDLE);
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      tx_st_ff <= fbs_pkg::FBS_ST_IDLE;
      tx_cnt_ff <= 18'h00000;
      tx_bit_ff <= 4'h0;
      tx_sh_ff <= 10'h3ff;
      TXD <= 1'b1;
      TX_OE_N <= 1'b1;
    end else begin
      unique case (tx_st_ff)
        fbs_pkg::FBS_ST_IDLE: begin
          TX_OE_N <= 1'b1;
          TXD <= 1'b1;
          if (tx_out_valid) begin
            // frame: data lsb first, optional parity, stops
            tx_sh_ff <= {1'b1, (par == fbs_pkg::FBS_PAR_NONE) ? 1'b1 : par_bit, tx_out_data};
            tx_bit_ff <= 4'(8 + ((par != fbs_pkg::FBS_PAR_NONE) ? 1 : 0) + (stop2 ? 2 : 1));
            tx_cnt_ff <= div - 18'h00001;
            TXD <= 1'b0;
            TX_OE_N <= 1'b0;
            tx_st_ff <= fbs_pkg::FBS_ST_BITS;
          end
        end
        fbs_pkg::FBS_ST_BITS: begin
          if (tx_cnt_ff != 18'h00000) begin
            tx_cnt_ff <= tx_cnt_ff - 18'h00001;
          end else if (tx_bit_ff == 4'h0) begin
            tx_st_ff <= fbs_pkg::FBS_ST_IDLE;
          end else begin
            tx_cnt_ff <= div - 18'h00001;
            TXD <= tx_sh_ff[0];
            tx_sh_ff <= {1'b1, tx_sh_ff[9:1]};
            tx_bit_ff <= tx_bit_ff - 4'h1;
          end
        end
        default: tx_st_ff <= fbs_pkg::FBS_ST_IDLE;
      endcase
    end
  end
  // ************
  // rx path
  // ************
  logic [2:0] rx_sync_ff;
  logic rx_lvl_ff;
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      rx_sync_ff <= 3'h7;
      rx_lvl_ff <= 1'b1;
    end else begin
      rx_sync_ff <= {rx_sync_ff[1:0], RXD};
      if (rx_sync_ff[2] == rx_sync_ff[1]) begin
        rx_lvl_ff <= rx_sync_ff[2];
      end
    end
  end
  fbs_pkg::fbs_st_e rx_st_ff;
  logic [17:0] rx_cnt_ff;
  logic [3:0] rx_bit_ff;
  logic rx_par_ff;
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      rx_st_ff <= fbs_pkg::FBS_ST_IDLE;
      rx_cnt_ff <= 18'h00000;
      rx_bit_ff <= 4'h0;
      rx_byte_ff <= 8'h00;
      rx_par_ff <= 1'b0;
      rx_done <= 1'b0;
      rx_pe <= 1'b0;
      rx_fe <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      unique case (rx_st_ff)
        fbs_pkg::FBS_ST_IDLE: begin
          if (!rx_lvl_ff) begin
            rx_cnt_ff <= {1'b0, div[17:1]};
            rx_st_ff <= fbs_pkg::FBS_ST_START;
          end
        end
        fbs_pkg::FBS_ST_START: begin
          if (rx_cnt_ff != 18'h00000) begin
            rx_cnt_ff <= rx_cnt_ff - 18'h00001;
          end else if (rx_lvl_ff) begin
            rx_st_ff <= fbs_pkg::FBS_ST_IDLE;
          end else begin
            rx_cnt_ff <= div - 18'h00001;
            rx_bit_ff <= 4'h0;
            rx_par_ff <= (par == fbs_pkg::FBS_PAR_ODD);
            rx_st_ff <= fbs_pkg::FBS_ST_BITS;
          end
        end
        fbs_pkg::FBS_ST_BITS: begin
          if (rx_cnt_ff != 18'h00000) begin
            rx_cnt_ff <= rx_cnt_ff - 18'h00001;
          end else begin
            rx_cnt_ff <= div - 18'h00001;
            rx_bit_ff <= rx_bit_ff + 4'h1;
            if (rx_bit_ff < 4'h8) begin
              rx_byte_ff <= {rx_lvl_ff, rx_byte_ff[7:1]};
              rx_par_ff <= rx_par_ff ^ rx_lvl_ff;
            end else begin
              rx_pe <= (rx_par_ff != rx_lvl_ff);
            end
            if ((rx_bit_ff == 4'h7 && par == fbs_pkg::FBS_PAR_NONE) || rx_bit_ff == 4'h8) begin
              rx_st_ff <= fbs_pkg::FBS_ST_STOP;
              if (rx_bit_ff == 4'h7) begin
                rx_pe <= 1'b0;
              end
            end
          end
        end
        fbs_pkg::FBS_ST_STOP: begin
          if (rx_cnt_ff != 18'h00000) begin
            rx_cnt_ff <= rx_cnt_ff - 18'h00001;
          end else begin
            // only first stop bit is checked; second is idle time
            rx_fe <= !rx_lvl_ff;
            rx_done <= 1'b1;
            rx_st_ff <= fbs_pkg::FBS_ST_IDLE;
          end
        end
      endcase
    end
  end
  assign rx_push = rx_done;
  fbs_fifo #(.WIDTH(8), .DEPTH(`FBS_FIFO_DEPTH)) u_rxq (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .in_valid(rx_push),
    .in_ready(rx_in_ready),
    .in_data(rx_byte_ff),
    .out_valid(rx_out_valid),
    .out_ready(rx_out_ready),
    .out_data(rx_out_data)
  );
  // sticky errors: set wins over a status write clear
  wire logic clr = wr_ff && (addr_ff == `FBS_OFF_STATUS);
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      pe_ff <= 1'b0;
      fe_ff <= 1'b0;
      ovr_ff <= 1'b0;
    end else begin
      pe_ff <= (rx_done && rx_pe) || (pe_ff && !(clr && HWDATA[2]));
      fe_ff <= (rx_done && rx_fe) || (fe_ff && !(clr && HWDATA[3]));
      ovr_ff <= (rx_done && !rx_in_ready) || (ovr_ff && !(clr && HWDATA[4]));
    end
  end
endmodule

//--- tb/fbs_station_sva.sv
module fbs_station_sva (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic HSEL,
  input wire logic [7:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic TXD,
  input wire logic TX_OE_N,
  input wire logic SELECTOR_HALT,
  input wire logic RUN_STATE
);
  timeunit 1ns;
  timeprecision 1ps;
  logic tk;
  logic rd_tk;
  assign tk = HSEL && HREADY && HTRANS[1];
  assign rd_tk = tk && !HWRITE;
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_N);
  // ************
  // bus side
  // ************
  sequence s_rd_wait;
    !HREADYOUT ##1 HREADYOUT;
  endsequence
  a_bus_okay: assert property (HRESP == 1'b0) else $error("bus response not okay");
  a_write_no_wait: assert property (tk && HWRITE |=> HREADYOUT) else $error("write stalled");
  a_read_one_wait: assert property (rd_tk |=> s_rd_wait) else $error("read wait not one cycle");
  a_unmapped_zero: assert property (rd_tk && HADDR > 8'h14 |=> ##1 HRDATA == 32'h0)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property ($changed(HRDATA) |-> $past(rd_tk, 1) || $past(rd_tk, 2))
    else $error("read data changed without read");
  // ************
  // line side
  // ************
  a_tx_idle_high: assert property (TX_OE_N |-> TXD) else $error("line not idle high");
  a_start_driven: assert property ($fell(TXD) |-> !TX_OE_N) else $error("bit sent undriven");
  a_bit_min: assert property ($fell(TXD) |-> !TXD [*8]) else $error("low bit too short");
  a_halt_forces: assert property (SELECTOR_HALT [*6] |=> !RUN_STATE) else $error("run under halt");
  a_reset_idle: assert property (@(posedge REF_CLK) disable iff (1'b0)
    !RST_N |=> TXD && TX_OE_N && HREADYOUT && !RUN_STATE) else $error("reset state wrong");
endmodule

//--- tb/fbs_peer.sv
module fbs_peer (
  input wire logic clk,
  input wire logic txd,
  output logic rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  int bit_cyc = 133;
  logic [1:0] par = 2'h0;
  logic [7:0] rx_q[$];
  logic last_par;
  logic last_stop;
  initial rxd = 1'b1;
  function automatic logic pbit(input logic [7:0] d);
    return (par == 2'h2) ? ~^d : ^d;
  endfunction
  // samples mid-bit, so a wrong bit time shows as wrong data
  always begin : rx_side
    logic [7:0] d;
    @(negedge txd);
    repeat (bit_cyc / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (bit_cyc) @(posedge clk);
      d[i] = txd;
    end
    if (par != 2'h0) begin
      repeat (bit_cyc) @(posedge clk);
      last_par = txd;
    end
    repeat (bit_cyc) @(posedge clk);
    last_stop = txd;
    rx_q.push_back(d);
  end
  task automatic send(input logic [7:0] d, input logic bad_par);
    logic [10:0] f;
    f = (par == 2'h0) ? {2'b11, d, 1'b0} : {1'b1, pbit(d) ^ bad_par, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rxd <= f[i];
      repeat (bit_cyc) @(posedge clk);
    end
    rxd <= 1'b1;
  endtask
endmodule

//--- tb/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic REF_CLK, RST_N, HSEL, HWRITE, MASTER_RUN, SELECTOR_HALT;
  logic [7:0] HADDR;
  logic [1:0] HTRANS;
  logic [2:0] HSIZE;
  logic [31:0] HWDATA;
  logic [31:0] HRDATA;
  logic HREADYOUT, HRESP, RXD, TXD, TX_OE_N, RUN_STATE, LINE_NUM;
  logic [3:0] BUS_ADDR;
  logic [31:0] rd;
  int err_total = 0;
  int checked = 0;
  int cyc = 0;
  fbs_station uut (.REF_CLK(REF_CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .RXD(RXD), .TXD(TXD), .TX_OE_N(TX_OE_N),
    .MASTER_RUN(MASTER_RUN), .SELECTOR_HALT(SELECTOR_HALT), .RUN_STATE(RUN_STATE),
    .BUS_ADDR(BUS_ADDR), .LINE_NUM(LINE_NUM));
  fbs_peer peer (.clk(REF_CLK), .txd(TXD), .rxd(RXD));
  initial begin
    REF_CLK = 1'b0;
    forever #10 REF_CLK = ~REF_CLK;
  end
  // ************
  // helpers
  // ************
  task conclude;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge REF_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      err_total = err_total + 1;
      conclude();
    end
  end
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      $display("ERROR %s expected %h got %h", nm, exp, got);
      err_total++;
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HADDR <= a;
    HWRITE <= w;
    do @(posedge REF_CLK); while (HREADYOUT !== 1'b1);
    HTRANS <= 2'h0;
    HWDATA <= wd;
    do @(posedge REF_CLK); while (HREADYOUT !== 1'b1);
    rd = HRDATA;
  endtask
  task rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(nm, exp, rd);
  endtask
  task wait_rx(input int n);
    while (peer.rx_q.size() < n) @(posedge REF_CLK);
  endtask
  // ************
  // tests
  // ************
  initial begin
    RST_N = 1'b0;
    HSEL = 1'b0;
    HADDR = 8'h0;
    HTRANS = 2'h0;
    HWRITE = 1'b0;
    HSIZE = 3'h2;
    HWDATA = 32'h0;
    MASTER_RUN = 1'b0;
    SELECTOR_HALT = 1'b0;
    repeat (3) @(posedge REF_CLK);
    RST_N <= 1'b1;
    @(posedge REF_CLK);
    rdc("ctrl", 8'h00, 32'h0);
    rdc("station", 8'h04, 32'h1);
    rdc("unmapped", 8'h18, 32'h0);
    chk("line", 32'h0, 32'(LINE_NUM));
    chk("bus_addr", 32'h0, 32'(BUS_ADDR));
    bus(1'b1, 8'h14, 32'h0000_140a);
    rdc("counts", 8'h14, 32'h0000_140a);
    for (int r = 0; r < 7; r++) begin
      bus(1'b1, 8'h00, 32'h400 | 32'(r << 2));
      rdc("rate", 8'h00, 32'h400 | 32'(r << 2));
    end
    $display("test regs done");
    bus(1'b1, 8'h00, 32'h201);
    for (int s = 1; s < 9; s++) begin
      bus(1'b1, 8'h04, 32'(s));
      repeat (3) @(posedge REF_CLK);
      chk("bus_addr", 32'(s + 1), 32'(BUS_ADDR));
      chk("line", 32'h1, 32'(LINE_NUM));
    end
    MASTER_RUN <= 1'b1;
    repeat (8) @(posedge REF_CLK);
    chk("run", 32'h1, 32'(RUN_STATE));
    MASTER_RUN <= 1'b0;
    repeat (8) @(posedge REF_CLK);
    chk("halt", 32'h0, 32'(RUN_STATE));
    MASTER_RUN <= 1'b1;
    SELECTOR_HALT <= 1'b1;
    repeat (8) @(posedge REF_CLK);
    chk("sel_halt", 32'h0, 32'(RUN_STATE));
    SELECTOR_HALT <= 1'b0;
    $display("test remote done");
    // one byte sits in the shifter, sixteen in the fifo, the last is dropped
    bus(1'b1, 8'h00, 32'h0);
    for (int i = 0; i < 18; i++) bus(1'b1, 8'h0c, 32'(i));
    bus(1'b0, 8'h08, 32'h0);
    chk("tx_ready", 32'h0, 32'(rd[0]));
    wait_rx(17);
    repeat (1500) @(posedge REF_CLK);
    chk("tx_count", 32'd17, 32'(peer.rx_q.size()));
    for (int i = 0; i < 17; i++) chk("tx_byte", 32'(i), 32'(peer.rx_q[i]));
    peer.rx_q.delete();
    peer.bit_cyc = 266;
    bus(1'b1, 8'h00, 32'h100);
    bus(1'b1, 8'h0c, 32'ha5);
    wait_rx(1);
    chk("slow_byte", 32'ha5, 32'(peer.rx_q[0]));
    $display("test master done");
    peer.rx_q.delete();
    peer.bit_cyc = 2604;
    peer.par = 2'h1;
    bus(1'b1, 8'h00, 32'h3a);
    bus(1'b1, 8'h0c, 32'h3c);
    wait_rx(1);
    chk("ser_byte", 32'h3c, 32'(peer.rx_q[0]));
    chk("ser_par", 32'h0, 32'(peer.last_par));
    chk("ser_stop", 32'h1, 32'(peer.last_stop));
    peer.par = 2'h2;
    bus(1'b1, 8'h00, 32'h5a);
    peer.send(8'h96, 1'b1);
    repeat (50) @(posedge REF_CLK);
    bus(1'b0, 8'h08, 32'h0);
    chk("rx_flags", 32'h3, 32'(rd[3:1]));
    rdc("rxdata", 8'h10, 32'h196);
    bus(1'b1, 8'h08, 32'h1c);
    bus(1'b0, 8'h08, 32'h0);
    chk("err_clear", 32'h0, 32'(rd[4:2]));
    $display("test serial done");
    conclude();
  end
endmodule
bind fbs_station fbs_station_sva u_sva (.REF_CLK(REF_CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR),
  .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
  .HRESP(HRESP), .TXD(TXD), .TX_OE_N(TX_OE_N), .SELECTOR_HALT(SELECTOR_HALT), .RUN_STATE(RUN_STATE));
